// ===== asrs_pkg.sv
// Constants and types shared by the serial ready and sync logic
package asrs_pkg;

   // Serial word geometry
   localparam int unsigned COMM_W   = 8;
   localparam int unsigned WORD_W   = 16;
   localparam int unsigned CNT_W    = 5;
   localparam logic [CNT_W-1:0] LEN_COMM = 5'h08;
   localparam logic [CNT_W-1:0] LEN_WORD = 5'h10;

   // Communications byte layout
   localparam int unsigned COMM_RD_BIT = 6;
   localparam int unsigned SEL_LSB     = 0;
   localparam int unsigned SEL_W       = 4;

   // Serial register select codes
   localparam logic [SEL_W-1:0] SEL_STATUS = 4'h0;
   localparam logic [SEL_W-1:0] SEL_MODE   = 4'h1;
   localparam logic [SEL_W-1:0] SEL_MAIN   = 4'h2;
   localparam logic [SEL_W-1:0] SEL_AUX    = 4'h3;

   // Mode register layout and reset value
   localparam int unsigned MODE_LSB         = 0;
   localparam int unsigned MODE_W           = 3;
   localparam int unsigned MODE_MAIN_EN_BIT = 4;
   localparam int unsigned MODE_AUX_EN_BIT  = 5;
   localparam logic [WORD_W-1:0] MODE_RST   = 16'h0010;

   // Serial status word bits
   localparam int unsigned STAT_MAIN_BIT = 0;
   localparam int unsigned STAT_AUX_BIT  = 1;
   localparam int unsigned STAT_CAL_BIT  = 2;

   // Bus register byte offsets
   localparam int unsigned ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_MAIN_DAT = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_AUX_DAT  = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_EVENT    = 8'h14;

   // Event register bits
   localparam int unsigned EV_MAIN_PRE = 0;
   localparam int unsigned EV_AUX_PRE  = 1;
   localparam int unsigned EV_CAL_DONE = 2;

   // Interrupt bits
   localparam int unsigned IRQ_W         = 3;
   localparam int unsigned IRQ_MAIN_READ = 0;
   localparam int unsigned IRQ_AUX_READ  = 1;
   localparam int unsigned IRQ_MODE_WR   = 2;

   // Bus status register layout
   localparam int unsigned BST_FLAGS_LSB = 0;
   localparam int unsigned BST_MODE_LSB  = 8;
   localparam int unsigned BST_RDY_BIT   = 24;
   localparam int unsigned BST_FILT_BIT  = 25;

   localparam int unsigned HTRANS_ACT_BIT = 1;

   typedef enum logic [1:0] {
      FR_COMM  = 2'b00,
      FR_WRITE = 2'b01,
      FR_READ  = 2'b10
   } asrs_frame_t;

endpackage : asrs_pkg

// ===== asrs_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module asrs_sync #(
   parameter int unsigned W = 4
) (
   input  wire logic         ref_clk_in,
   input  wire logic         rst_b_in,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } asrs_sync_st_t;

   asrs_sync_st_t st;
   asrs_sync_st_t next_st;

   always_comb begin
      next_st        = st;
      next_st.meta   = async_in;
      next_st.stable = st.meta;
   end

   // Idle level of every pin is high
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st <= '1;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.stable;

endmodule : asrs_sync

// ===== asrs_shifter.sv
// Serial shift engine: sample on rising, drive on falling clock edge
`timescale 1ns/1ps
module asrs_shifter (
   input  wire logic                         ref_clk_in,
   input  wire logic                         rst_b_in,
   input  wire logic                         sclk_rise_in,
   input  wire logic                         sclk_fall_in,
   input  wire logic                         sel_in,
   input  wire logic                         din_in,
   input  wire logic [asrs_pkg::CNT_W-1:0]   len_in,
   input  wire logic                         load_in,
   input  wire logic [asrs_pkg::WORD_W-1:0]  load_word_in,
   output logic      [asrs_pkg::WORD_W-1:0]  word_out,
   output logic                              word_done_out,
   output logic      [asrs_pkg::CNT_W-1:0]   bit_cnt_out,
   output logic                              dout_out
);

   typedef struct packed {
      logic [asrs_pkg::WORD_W-1:0] shin;
      logic [asrs_pkg::WORD_W-1:0] shout;
      logic [asrs_pkg::CNT_W-1:0]  cnt;
      logic                        done;
      logic                        dout;
   } asrs_shift_st_t;

   asrs_shift_st_t st;
   asrs_shift_st_t next_st;

   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      // RL2 RL16 gaps keep position
      if (sel_in && sclk_rise_in) begin
         next_st.shin  = {st.shin[asrs_pkg::WORD_W-2:0], din_in};
         next_st.shout = {st.shout[asrs_pkg::WORD_W-2:0], 1'b0};
         if (st.cnt + 5'h01 == len_in) begin
            next_st.cnt  = '0;
            next_st.done = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 5'h01;
         end
      end
      if (sel_in && sclk_fall_in) begin
         next_st.dout = st.shout[asrs_pkg::WORD_W-1];
      end
      if (load_in) begin
         next_st.shout = load_word_in;
         next_st.dout  = load_word_in[asrs_pkg::WORD_W-1];
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign word_out      = st.shin;
   assign word_done_out = st.done;
   assign bit_cnt_out   = st.cnt;
   assign dout_out      = st.dout;

endmodule : asrs_shifter

// ===== asrs_top.sv
// Serial port, filter sync and data-ready control with AHB-Lite registers
`timescale 1ns/1ps
// Function
// RL1: Host supplies the serial clock for every read and write.
// RL2: Accept continuous or gapped serial clock, keeping contents across gaps.
// RL3: Sync input low holds filter, filter control and calibration control reset.
// RL4: Shared sync lets several devices restart filters from one point.
// RL5: Ready output low while main or aux channel holds unread result.
// RL6: Ready returns high after a full word read, not a partial one.
// RL7: Unread result: ready goes high shortly before next data update.
// RL8: Host avoids starting a read while ready is high.
// RL9: Ready goes low when a calibration cycle finishes.
// RL10: Ready output is NOR of main and aux ready flags.
// RL11: With one channel disabled, ready follows only the active channel.
// RL12: After calibration ready stays low until mode bits are written.
// RL13: Active-low select; tied low gives three-wire operation.
// RL14: Input bits go via shift register to register chosen by select bits.
// RL15: Reset returns control, interface and filter logic to power-on state.
// RL16: Shift in and out on opposite edges; hold position when paused.
module asrs_top (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic        hready_in,
   input  wire logic [31:0] hwdata_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   input  wire logic        sclk_in,
   input  wire logic        cs_b_in,
   input  wire logic        din_in,
   input  wire logic        sync_b_in,
   output logic             dout_out,
   output logic             rdy_b_out,
   output logic             filter_reset_out,
   output logic [2:0]       mode_out,
   output logic             main_en_out,
   output logic             aux_en_out,
   output logic             start_out,
   output logic             irq_out
);

   typedef struct packed {
      asrs_pkg::asrs_frame_t            frame;
      logic [asrs_pkg::SEL_W-1:0]       sel;
      logic [asrs_pkg::WORD_W-1:0]      mode_reg;
      logic [asrs_pkg::WORD_W-1:0]      main_data;
      logic [asrs_pkg::WORD_W-1:0]      aux_data;
      logic                             main_flag;
      logic                             aux_flag;
      logic                             cal_hold;
      logic                             rdy_b;
      logic                             filt_rst;
      logic                             start;
      logic [asrs_pkg::IRQ_W-1:0]       irq_stat;
      logic [asrs_pkg::IRQ_W-1:0]       irq_mask;
      logic                             irq;
      logic                             wr_pend;
      logic [asrs_pkg::ADDR_W-1:0]      wr_addr;
      logic [31:0]                      hrdata;
      logic                             sclk_prev;
      logic                             load;
      logic [asrs_pkg::WORD_W-1:0]      load_word;
      logic [asrs_pkg::CNT_W-1:0]       len;
   } asrs_top_st_t;

   asrs_top_st_t st;
   asrs_top_st_t next_st;

   logic [3:0]                   pins_sync;
   logic                         sclk_s;
   logic                         cs_b_s;
   logic                         din_s;
   logic                         sync_b_s;
   logic                         sclk_rise;
   logic                         sclk_fall;
   logic [asrs_pkg::WORD_W-1:0]  word;
   logic                         word_done;
   logic [asrs_pkg::CNT_W-1:0]   bit_cnt;
   logic                         addr_take;

   // Pin inputs pass two flops first
   asrs_sync #(
      .W (4)
   ) u_sync (
      .ref_clk_in (ref_clk_in),
      .rst_b_in   (rst_b_in),
      .async_in   ({sclk_in, cs_b_in, din_in, sync_b_in}),
      .sync_out   (pins_sync)
   );

   assign sclk_s    = pins_sync[3];
   assign cs_b_s    = pins_sync[2];
   assign din_s     = pins_sync[1];
   assign sync_b_s  = pins_sync[0];
   // RL1 edges of host clock
   assign sclk_rise = sclk_s & ~st.sclk_prev;
   assign sclk_fall = ~sclk_s & st.sclk_prev;

   // RL13 select frames shifting
   asrs_shifter u_shift (
      .ref_clk_in    (ref_clk_in),
      .rst_b_in      (rst_b_in),
      .sclk_rise_in  (sclk_rise),
      .sclk_fall_in  (sclk_fall),
      .sel_in        (~cs_b_s),
      .din_in        (din_s),
      .len_in        (st.len),
      .load_in       (st.load),
      .load_word_in  (st.load_word),
      .word_out      (word),
      .word_done_out (word_done),
      .bit_cnt_out   (bit_cnt),
      .dout_out      (dout_out)
   );

   assign addr_take = hsel_in & htrans_in[asrs_pkg::HTRANS_ACT_BIT] & hready_in;

   function automatic logic [asrs_pkg::WORD_W-1:0] serial_read(
      input logic [asrs_pkg::SEL_W-1:0] sel,
      input asrs_top_st_t               s
   );
      logic [asrs_pkg::WORD_W-1:0] r;
      r = '0;
      unique case (sel)
         asrs_pkg::SEL_STATUS: begin
            r[asrs_pkg::STAT_MAIN_BIT] = s.main_flag;
            r[asrs_pkg::STAT_AUX_BIT]  = s.aux_flag;
            r[asrs_pkg::STAT_CAL_BIT]  = s.cal_hold;
         end
         asrs_pkg::SEL_MODE: r = s.mode_reg;
         asrs_pkg::SEL_MAIN: r = s.main_data;
         asrs_pkg::SEL_AUX:  r = s.aux_data;
         default:            r = '0;
      endcase
      return r;
   endfunction : serial_read

   function automatic logic [31:0] bus_read(
      input logic [asrs_pkg::ADDR_W-1:0] addr,
      input asrs_top_st_t                s
   );
      logic [31:0] r;
      r = '0;
      unique case (addr)
         asrs_pkg::OFF_STATUS: begin
            r[asrs_pkg::BST_FLAGS_LSB +: asrs_pkg::WORD_W] = serial_read(asrs_pkg::SEL_STATUS, s);
            r[asrs_pkg::BST_MODE_LSB +: asrs_pkg::WORD_W]  = s.mode_reg;
            r[asrs_pkg::BST_RDY_BIT]                       = s.rdy_b;
            r[asrs_pkg::BST_FILT_BIT]                      = s.filt_rst;
         end
         asrs_pkg::OFF_IRQ_STAT: r[asrs_pkg::IRQ_W-1:0] = s.irq_stat;
         asrs_pkg::OFF_IRQ_MASK: r[asrs_pkg::IRQ_W-1:0] = s.irq_mask;
         asrs_pkg::OFF_MAIN_DAT: r[asrs_pkg::WORD_W-1:0] = s.main_data;
         asrs_pkg::OFF_AUX_DAT:  r[asrs_pkg::WORD_W-1:0] = s.aux_data;
         default:                r = '0;
      endcase
      return r;
   endfunction : bus_read

   always_comb begin
      logic [asrs_pkg::IRQ_W-1:0] irq_set;
      logic [asrs_pkg::IRQ_W-1:0] irq_clr;
      logic                       main_en;
      logic                       aux_en;
      logic                       main_rd;
      logic                       aux_rd;
      logic                       main_pre;
      logic                       aux_pre;
      logic                       main_upd;
      logic                       aux_upd;
      logic                       cal_done;
      logic                       mode_wr;
      irq_set   = '0;
      irq_clr   = '0;
      main_rd   = 1'b0;
      aux_rd    = 1'b0;
      main_pre  = 1'b0;
      aux_pre   = 1'b0;
      main_upd  = 1'b0;
      aux_upd   = 1'b0;
      cal_done  = 1'b0;
      mode_wr   = 1'b0;
      main_en   = 1'b0;
      aux_en    = 1'b0;
      next_st   = st;
      next_st.sclk_prev = sclk_s;
      next_st.load      = 1'b0;
      next_st.start     = 1'b0;

      // RL14 word routed by select bits
      if (word_done) begin
         unique case (st.frame)
            asrs_pkg::FR_COMM: begin
               next_st.sel = word[asrs_pkg::SEL_LSB +: asrs_pkg::SEL_W];
               next_st.len = asrs_pkg::LEN_WORD;
               if (word[asrs_pkg::COMM_RD_BIT]) begin
                  next_st.frame     = asrs_pkg::FR_READ;
                  next_st.load      = 1'b1;
                  next_st.load_word = serial_read(word[asrs_pkg::SEL_LSB +: asrs_pkg::SEL_W], st);
               end else begin
                  next_st.frame = asrs_pkg::FR_WRITE;
               end
            end
            asrs_pkg::FR_WRITE: begin
               next_st.frame = asrs_pkg::FR_COMM;
               next_st.len   = asrs_pkg::LEN_COMM;
               mode_wr       = (st.sel == asrs_pkg::SEL_MODE);
            end
            asrs_pkg::FR_READ: begin
               next_st.frame = asrs_pkg::FR_COMM;
               next_st.len   = asrs_pkg::LEN_COMM;
               // RL6 only a whole word counts
               main_rd       = (st.sel == asrs_pkg::SEL_MAIN);
               aux_rd        = (st.sel == asrs_pkg::SEL_AUX);
            end
            default: begin
               next_st.frame = asrs_pkg::FR_COMM;
               next_st.len   = asrs_pkg::LEN_COMM;
            end
         endcase
      end

      // Bus address phase; zero wait states
      next_st.wr_pend = 1'b0;
      if (addr_take) begin
         if (hwrite_in) begin
            next_st.wr_pend = 1'b1;
            next_st.wr_addr = haddr_in[asrs_pkg::ADDR_W-1:0];
         end else begin
            next_st.hrdata = bus_read(haddr_in[asrs_pkg::ADDR_W-1:0], st);
         end
      end

      // Bus data phase
      if (st.wr_pend) begin
         unique case (st.wr_addr)
            asrs_pkg::OFF_IRQ_STAT: irq_clr = hwdata_in[asrs_pkg::IRQ_W-1:0];
            asrs_pkg::OFF_IRQ_MASK: next_st.irq_mask = hwdata_in[asrs_pkg::IRQ_W-1:0];
            asrs_pkg::OFF_MAIN_DAT: begin
               next_st.main_data = hwdata_in[asrs_pkg::WORD_W-1:0];
               main_upd          = 1'b1;
            end
            asrs_pkg::OFF_AUX_DAT: begin
               next_st.aux_data = hwdata_in[asrs_pkg::WORD_W-1:0];
               aux_upd          = 1'b1;
            end
            asrs_pkg::OFF_EVENT: begin
               main_pre = hwdata_in[asrs_pkg::EV_MAIN_PRE];
               aux_pre  = hwdata_in[asrs_pkg::EV_AUX_PRE];
               cal_done = hwdata_in[asrs_pkg::EV_CAL_DONE];
            end
            default: begin
               irq_clr = '0;
            end
         endcase
      end

      // RL12 mode write starts conversion or calibration
      if (mode_wr) begin
         next_st.mode_reg = word;
         next_st.start    = 1'b1;
         if (st.cal_hold) begin
            next_st.cal_hold  = 1'b0;
            next_st.main_flag = 1'b0;
            next_st.aux_flag  = 1'b0;
         end
      end

      // RL6 full read clears flag unless calibration holds it
      if (main_rd && !st.cal_hold) begin
         next_st.main_flag = 1'b0;
      end
      if (aux_rd && !st.cal_hold) begin
         next_st.aux_flag = 1'b0;
      end
      // RL7 stale result withdrawn before update
      if (main_pre && !st.cal_hold) begin
         next_st.main_flag = 1'b0;
      end
      if (aux_pre && !st.cal_hold) begin
         next_st.aux_flag = 1'b0;
      end

      // RL5 new result sets flag
      if (main_upd) begin
         next_st.main_flag = 1'b1;
      end
      if (aux_upd) begin
         next_st.aux_flag = 1'b1;
      end
      // RL9 calibration end sets main flag, pulling ready low when main channel is enabled
      if (cal_done) begin
         next_st.main_flag = 1'b1;
         next_st.cal_hold  = 1'b1;
      end

      // RL3 sync low holds filter and calibration control in reset
      // RL4 all devices restart together on release
      next_st.filt_rst = ~sync_b_s;
      if (!sync_b_s) begin
         next_st.main_flag = 1'b0;
         next_st.aux_flag  = 1'b0;
         next_st.cal_hold  = 1'b0;
      end

      main_en = next_st.mode_reg[asrs_pkg::MODE_MAIN_EN_BIT];
      aux_en  = next_st.mode_reg[asrs_pkg::MODE_AUX_EN_BIT];
      // RL10 NOR of flags
      // RL11 disabled channel ignored
      next_st.rdy_b = ~((next_st.main_flag & main_en) | (next_st.aux_flag & aux_en));

      irq_set[asrs_pkg::IRQ_MAIN_READ] = main_rd;
      irq_set[asrs_pkg::IRQ_AUX_READ]  = aux_rd;
      irq_set[asrs_pkg::IRQ_MODE_WR]   = mode_wr;
      // Set wins over write-one clear
      next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;
      next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
   end

   // RL15 reset to power-on state
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st           <= '0;
         st.frame     <= asrs_pkg::FR_COMM;
         st.mode_reg  <= asrs_pkg::MODE_RST;
         st.rdy_b     <= 1'b1;
         st.sclk_prev <= 1'b1;
         st.len       <= asrs_pkg::LEN_COMM;
      end else begin
         st <= next_st;
      end
   end

   assign hrdata_out       = st.hrdata;
   assign hreadyout_out    = 1'b1;
   assign hresp_out        = 1'b0;
   assign rdy_b_out        = st.rdy_b;
   assign filter_reset_out = st.filt_rst;
   assign mode_out         = st.mode_reg[asrs_pkg::MODE_LSB +: asrs_pkg::MODE_W];
   assign main_en_out      = st.mode_reg[asrs_pkg::MODE_MAIN_EN_BIT];
   assign aux_en_out       = st.mode_reg[asrs_pkg::MODE_AUX_EN_BIT];
   assign start_out        = st.start;
   assign irq_out          = st.irq;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);

   a_rdy_from_flags: assert property ( // RL10
      !rdy_b_out |-> ((st.main_flag && main_en_out) || (st.aux_flag && aux_en_out)))
      else $error("ready low without an enabled ready flag");

   a_rdy_active_chan: assert property ( // RL11
      (st.aux_flag && !st.main_flag && !aux_en_out) |-> rdy_b_out)
      else $error("disabled channel drives ready");

   a_full_read_clr: assert property ( // RL6
      (word_done && st.frame == asrs_pkg::FR_READ && st.sel == asrs_pkg::SEL_MAIN
       && !st.cal_hold && sync_b_s && !(st.wr_pend && st.wr_addr == asrs_pkg::OFF_MAIN_DAT)
       && !(st.wr_pend && st.wr_addr == asrs_pkg::OFF_EVENT))
      |=> !st.main_flag)
      else $error("main flag survived a full read");

   a_partial_keep: assert property ( // RL6
      (st.main_flag && sync_b_s && !word_done && !st.wr_pend) |=> st.main_flag)
      else $error("main flag dropped without a full read");

   a_preupd_clr: assert property ( // RL7
      (st.wr_pend && st.wr_addr == asrs_pkg::OFF_EVENT && hwdata_in[asrs_pkg::EV_MAIN_PRE]
       && !hwdata_in[asrs_pkg::EV_CAL_DONE] && !st.cal_hold)
      |=> !st.main_flag)
      else $error("pre-update did not withdraw main flag");

   a_cal_rdy_low: assert property ( // RL9
      (st.wr_pend && st.wr_addr == asrs_pkg::OFF_EVENT && hwdata_in[asrs_pkg::EV_CAL_DONE] && sync_b_s
       && !(word_done && st.frame == asrs_pkg::FR_WRITE))
      |=> st.cal_hold && st.main_flag && (!main_en_out || !rdy_b_out))
      else $error("calibration end did not assert ready");

   a_cal_hold_keep: assert property ( // RL12
      (st.cal_hold && sync_b_s && !(word_done && st.frame == asrs_pkg::FR_WRITE)) |=> st.cal_hold)
      else $error("calibration hold released without mode write");

   a_sync_holds: assert property ( // RL3
      (!sync_b_s) [*2] |=> (filter_reset_out && !st.main_flag && !st.aux_flag && rdy_b_out))
      else $error("sync low did not hold filter state");

   a_mode_start: assert property ( // RL12
      (word_done && st.frame == asrs_pkg::FR_WRITE && st.sel == asrs_pkg::SEL_MODE)
      |=> start_out ##1 !start_out)
      else $error("mode write did not give one start pulse");

   a_pause_holds: assert property ( // RL16
      (!sclk_rise && !word_done) |=> $stable(bit_cnt))
      else $error("shift position moved without a clock edge");

   a_bus_okay: assert property ( // zero-wait OKAY bus response
      hreadyout_out && !hresp_out)
      else $error("bus response not zero-wait OKAY");

endmodule : asrs_top

// ===== asrs_host.sv
// Serial host model: gapped shift clock, select and data-in
`timescale 1ns/1ps
module asrs_host (
   output logic      sclk_out,
   output logic      cs_b_out,
   output logic      din_out,
   input  wire logic dout_in
);
   logic [15:0] rd;
   initial begin
      sclk_out = 1'b1;
      cs_b_out = 1'b1;
      din_out = 1'b0;
      rd = 16'h0000;
   end
   task automatic shift(input logic [15:0] v, input int n);
      if (cs_b_out) begin
         cs_b_out = 1'b0;
         #80;
      end
      for (int i = n - 1; i >= 0; i--) begin
         sclk_out = 1'b0;
         din_out = v[i];
         #80;
         sclk_out = 1'b1;
         #80;
         rd = {rd[14:0], dout_in};
      end
   endtask : shift
   // Released data line shows no stale bit
   task automatic done();
      #80;
      cs_b_out = 1'b1;
      din_out = ~din_out;
   endtask : done
endmodule : asrs_host

// ===== tb.sv
// Testbench for the serial ready and sync block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
   logic        clk, rst_b, hsel, hwrite, hrdy, hresp, sclk, cs_b, din, dout, rdy_b, sync_b, filt, aux_en, irq;
   logic        main_en, start;
   int          starts = 0;
   logic [1:0]  htrans;
   logic [2:0]  hsize, mode;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int          num_errors = 0;
   int          cmp_count = 0;
   asrs_host host (.sclk_out(sclk), .cs_b_out(cs_b), .din_out(din), .dout_in(dout));
   asrs_top dut (.ref_clk_in(clk), .rst_b_in(rst_b), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hrdy), .hwdata_in(hwdata), .hrdata_out(hrdata),
      .hreadyout_out(hrdy), .hresp_out(hresp), .sclk_in(sclk), .cs_b_in(cs_b), .din_in(din),
      .sync_b_in(sync_b), .dout_out(dout), .rdy_b_out(rdy_b), .filter_reset_out(filt), .mode_out(mode),
      .main_en_out(main_en), .aux_en_out(aux_en), .start_out(start), .irq_out(irq));
   task automatic results();
      if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task automatic hwait();
      for (int n = 0; n < 20; n++) begin
         @(posedge clk);
         if (hrdy === 1'b1) return;
      end
      num_errors++;
      results();
   endtask : hwait
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      hwait();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      hwait();
      rd = hrdata;
      #1;
   endtask : ahb
   task automatic settle();
      repeat (6) @(posedge clk);
      #1;
   endtask : settle
   task automatic srd(input logic [7:0] c);
      host.shift({8'h00, c}, 8);
      #400;
      host.shift(16'h0000, 16);
      host.done();
      settle();
   endtask : srd
   task automatic mwr(input logic [15:0] v);
      host.shift(16'h0001, 8);
      host.shift(v, 16);
      host.done();
      settle();
   endtask : mwr
   task automatic t_reset();
      #1;
      `CHK("rdy_b", 1'b1, rdy_b)
      `CHK("hresp", 1'b0, hresp)
      `CHK("hready", 1'b1, hrdy)
      ahb(0, asrs_pkg::OFF_STATUS, 0);
      `CHK("status", 32'h0100_1000, rd)
      ahb(0, 8'h3C, 0);
      `CHK("unmapped", 32'h0000_0000, rd)
   endtask : t_reset
   task automatic t_read();
      ahb(1, asrs_pkg::OFF_MAIN_DAT, 32'h0000_A5C3);
      `CHK("rdy_b", 1'b0, rdy_b)
      host.shift(16'h0042, 8);
      #400;
      host.shift(16'h0000, 8);
      settle();
      `CHK("rdy_b", 1'b0, rdy_b)
      host.shift(16'h0000, 8);
      host.done();
      settle();
      `CHK("main word", 16'hA5C3, host.rd)
      `CHK("rdy_b", 1'b1, rdy_b)
   endtask : t_read
   task automatic t_mode();
      host.shift(16'h0001, 8);
      host.shift(16'h0000, 8);
      #400;
      host.shift(16'h0023, 8);
      host.done();
      settle();
      `CHK("mode", 3'h3, mode)
      `CHK("aux_en", 1'b1, aux_en)
      `CHK("main_en", 1'b0, main_en)
      ahb(1, asrs_pkg::OFF_AUX_DAT, 32'h0000_1234);
      `CHK("rdy_b", 1'b0, rdy_b)
      ahb(1, asrs_pkg::OFF_EVENT, 32'h0000_0002);
      `CHK("rdy_b", 1'b1, rdy_b)
      mwr(16'h0010);
      `CHK("main_en", 1'b1, main_en)
      `CHK("aux_en", 1'b0, aux_en)
      ahb(1, asrs_pkg::OFF_AUX_DAT, 32'h0000_0055);
      `CHK("rdy_b", 1'b1, rdy_b)
      srd(8'h40);
      `CHK("status word", 16'h0002, host.rd)
   endtask : t_mode
   task automatic t_cal();
      ahb(1, asrs_pkg::OFF_EVENT, 32'h0000_0004);
      `CHK("rdy_b", 1'b0, rdy_b)
      srd(8'h42);
      `CHK("main word", 16'hA5C3, host.rd)
      ahb(1, asrs_pkg::OFF_EVENT, 32'h0000_0001);
      `CHK("rdy_b", 1'b0, rdy_b)
      mwr(16'h0010);
      `CHK("rdy_b", 1'b1, rdy_b)
      `CHK("starts", 32'd3, starts)
   endtask : t_cal
   task automatic t_sync();
      ahb(1, asrs_pkg::OFF_MAIN_DAT, 32'h0000_0077);
      @(posedge clk);
      sync_b <= 1'b0;
      settle();
      `CHK("filter_reset", 1'b1, filt)
      `CHK("rdy_b", 1'b1, rdy_b)
      @(posedge clk);
      sync_b <= 1'b1;
      settle();
      `CHK("filter_reset", 1'b0, filt)
   endtask : t_sync
   task automatic t_irq();
      ahb(1, asrs_pkg::OFF_IRQ_MASK, 32'h0000_0007);
      settle();
      `CHK("irq", 1'b1, irq)
      ahb(0, asrs_pkg::OFF_IRQ_STAT, 0);
      `CHK("irq_stat", 32'h0000_0005, rd)
      ahb(1, asrs_pkg::OFF_IRQ_STAT, 32'h0000_0007);
      settle();
      `CHK("irq", 1'b0, irq)
   endtask : t_irq
   task automatic t_rst2();
      ahb(1, asrs_pkg::OFF_EVENT, 32'h0000_0004);
      `CHK("rdy_b", 1'b0, rdy_b)
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset();
   endtask : t_rst2
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (start === 1'b1) starts <= starts + 1;
   end
   initial begin
      rst_b = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      haddr = 32'h0000_0000;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      sync_b = 1'b1;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_read();
      t_mode();
      t_cal();
      t_sync();
      t_irq();
      t_rst2();
      results();
   end
endmodule : tb
